// >>> src/nav_subframe_reporter.sv
// Subframe report framer: collects decoded words, emits reports
`default_nettype none
// How it works
// - One report per complete subframe when enabled
// - Bits kept in order with preamble, parity
// - Payload in 32-bit words, count in header
// - Drop incomplete or parity-failed subframes
// - Invert data bits before output where needed
// - GPS L1C/A: ten words in order
// - GLONASS string in three words, idle zero
// - GLONASS fourth word: frame, superframe, zero unknown
// - Unidentified GLONASS satellite reports 255
// - BeiDou: 30 bits low, two pad
// - Galileo page pair in eight words
// - SBAS and QZSS L1S: eight words
// - QZSS L1C/A, L2C copy GPS layouts
// - Fixed constellation identifier codes
// - Word counts and signal codes per signal
module nav_subframe_reporter
    import nav_report_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic report_enable,
    input wire logic word_valid,
    input wire logic [WORD_W-1:0] word_data,
    input wire logic end_valid,
    input wire logic end_parity_ok,
    input wire logic [7:0] end_gnss_id,
    input wire logic [7:0] end_sig_id,
    input wire logic [7:0] end_sv_id,
    input wire logic end_sv_known,
    input wire logic end_prev_d30,
    input wire logic [15:0] end_glo_frame,
    input wire logic [15:0] end_glo_super,
    output logic in_ready,
    output logic rpt_valid,
    output logic [WORD_W-1:0] rpt_data,
    output logic rpt_first,
    output logic rpt_last,
    input wire logic rpt_ready,
    output logic drop_pulse,
    output logic [15:0] sent_count,
    output logic [15:0] drop_count
);
    // ------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------
    logic [WORD_W-1:0] mem_r [MAX_WORDS];
    state_type state_r;
    logic [IDX_W-1:0] wr_idx_r;
    logic overflow_r;
    logic [IDX_W-1:0] rd_idx_r;
    logic [7:0] gnss_r;
    logic [7:0] sig_r;
    logic [7:0] sv_r;
    logic [7:0] wc_r;
    fmt_type fmt_r;
    logic prev_d30_r;
    logic [15:0] glo_frame_r;
    logic [15:0] glo_super_r;
    logic [15:0] sent_r;
    logic [15:0] drop_r;
    logic drop_pulse_r;

    logic lk_known;
    logic [7:0] lk_wc;
    logic [7:0] lk_src;
    fmt_type lk_fmt;
    logic word_take;
    logic end_take;
    logic sf_good;
    logic load;
    logic [WORD_W-1:0] shaped;
    logic prev_bit;
    logic [IDX_W-1:0] rd_prev;
    logic [IDX_W-1:0] rd_sel;

    // Final payload index of the report in flight
    function automatic logic last_beat(input logic [IDX_W-1:0] idx, input logic [7:0] count);
        return {4'h0, idx} == count - 8'h01;
    endfunction : last_beat

    // ------------------------------------------------------------
    // Layout lookup and word shaping
    // ------------------------------------------------------------
    sig_format_lookup u_lookup (
        .gnss_id(end_gnss_id),
        .sig_id(end_sig_id),
        .known(lk_known),
        .word_count(lk_wc),
        .src_words(lk_src),
        .fmt(lk_fmt)
    );

    // Only the lowest bit of the prior word matters for inversion
    assign rd_prev = rd_idx_r - 4'h1;
    assign prev_bit = (rd_idx_r == '0) ? prev_d30_r : mem_r[rd_prev][0];
    // Index runs one past the payload while draining; keep the read in range
    assign rd_sel = (rd_idx_r < IDX_W'(MAX_WORDS)) ? rd_idx_r : '0;

    nav_word_shaper u_shaper (
        .fmt(fmt_r),
        .idx(rd_idx_r),
        .raw(mem_r[rd_sel]),
        .prev_d30(prev_bit),
        .glo_frame(glo_frame_r),
        .glo_super(glo_super_r),
        .word(shaped)
    );

    // ------------------------------------------------------------
    // Collection
    // ------------------------------------------------------------
    // Input is refused while a report drains; one subframe buffer only
    assign word_take = word_valid && in_ready;
    assign end_take = end_valid && in_ready;
    // complete, parity passed, known signal
    // A word arriving with the end marker breaks the count, so it is dropped
    assign sf_good = report_enable && end_parity_ok && lk_known && !overflow_r && !word_take
                     && ({4'h0, wr_idx_r} == lk_src);

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            in_ready <= 1'b0;
        end else begin
            in_ready <= (state_r == ST_COLLECT) && !end_take;
            // Reopen on the edge the last beat is taken
            if (state_r == ST_DRAIN && load) begin
                in_ready <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (word_take && wr_idx_r < IDX_W'(MAX_WORDS)) begin
            mem_r[wr_idx_r] <= word_data;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_idx_r <= '0;
            overflow_r <= 1'b0;
        end else if (end_take) begin
            wr_idx_r <= '0;
            overflow_r <= 1'b0;
        end else if (word_take) begin
            if (wr_idx_r < IDX_W'(MAX_WORDS)) begin
                wr_idx_r <= wr_idx_r + 4'h1;
            end else begin
                overflow_r <= 1'b1;
            end
        end
    end

    // Header fields latched with the end marker
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gnss_r <= '0;
            sig_r <= '0;
            sv_r <= '0;
            wc_r <= '0;
            fmt_r <= FMT_PASS;
            prev_d30_r <= 1'b0;
            glo_frame_r <= '0;
            glo_super_r <= '0;
        end else if (end_take && sf_good) begin
            gnss_r <= end_gnss_id;
            sig_r <= end_sig_id;
            if (end_gnss_id == GNSS_GLO && !end_sv_known) begin
                sv_r <= SV_UNKNOWN;
            end else begin
                sv_r <= end_sv_id;
            end
            wc_r <= lk_wc;
            fmt_r <= lk_fmt;
            prev_d30_r <= end_prev_d30;
            glo_frame_r <= end_glo_frame;
            glo_super_r <= end_glo_super;
        end
    end

    // ------------------------------------------------------------
    // Report sequencing
    // ------------------------------------------------------------
    // next beat loads when slot empty or taken
    assign load = !rpt_valid || rpt_ready;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_COLLECT;
        end else begin
            unique case (state_r)
                ST_COLLECT: begin
                    if (end_take && sf_good) begin
                        state_r <= ST_HEADER;
                    end
                end
                ST_HEADER: begin
                    if (load) begin
                        state_r <= ST_PAYLOAD;
                    end
                end
                ST_PAYLOAD: begin
                    if (load && last_beat(rd_idx_r, wc_r)) begin
                        state_r <= ST_DRAIN;
                    end
                end
                ST_DRAIN: begin
                    if (load) begin
                        state_r <= ST_COLLECT;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_idx_r <= '0;
        end else if (state_r == ST_HEADER) begin
            rd_idx_r <= '0;
        end else if (state_r == ST_PAYLOAD && load) begin
            rd_idx_r <= rd_idx_r + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Output beats
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rpt_valid <= 1'b0;
            rpt_data <= '0;
            rpt_first <= 1'b0;
            rpt_last <= 1'b0;
        end else if (load) begin
            unique case (state_r)
                ST_HEADER: begin
                    rpt_valid <= 1'b1;
                    rpt_first <= 1'b1;
                    rpt_last <= 1'b0;
                    rpt_data <= '0;
                    rpt_data[HDR_GNSS_LSB +: 8] <= gnss_r;
                    rpt_data[HDR_SV_LSB +: 8] <= sv_r;
                    rpt_data[HDR_SIG_LSB +: 8] <= sig_r;
                    rpt_data[HDR_WC_LSB +: 8] <= wc_r;
                end
                ST_PAYLOAD: begin
                    rpt_valid <= 1'b1;
                    rpt_first <= 1'b0;
                    rpt_last <= last_beat(rd_idx_r, wc_r);
                    rpt_data <= shaped;
                end
                ST_COLLECT, ST_DRAIN: begin
                    rpt_valid <= 1'b0;
                    rpt_first <= 1'b0;
                    rpt_last <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Statistics
    // ------------------------------------------------------------
    // Counters wrap; host takes differences
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sent_r <= '0;
            drop_r <= '0;
            drop_pulse_r <= 1'b0;
        end else begin
            drop_pulse_r <= 1'b0;
            if (state_r == ST_DRAIN && load) begin
                sent_r <= sent_r + 16'h0001;
            end
            if (end_take && !sf_good && report_enable) begin
                drop_r <= drop_r + 16'h0001;
                drop_pulse_r <= 1'b1;
            end
        end
    end

    assign drop_pulse = drop_pulse_r;
    assign sent_count = sent_r;
    assign drop_count = drop_r;
endmodule : nav_subframe_reporter
`default_nettype wire

// >>> inc/nav_report_pkg.sv
// Constants and types shared by the subframe report framer
`default_nettype none
package nav_report_pkg;
    localparam int WORD_W = 32;
    localparam int MAX_WORDS = 10;
    localparam int IDX_W = 4;

    // Constellation identifier codes
    localparam logic [7:0] GNSS_GPS = 8'h00;
    localparam logic [7:0] GNSS_SBAS = 8'h01;
    localparam logic [7:0] GNSS_GAL = 8'h02;
    localparam logic [7:0] GNSS_BDS = 8'h03;
    localparam logic [7:0] GNSS_QZSS = 8'h05;
    localparam logic [7:0] GNSS_GLO = 8'h06;

    // Signal identifier codes
    localparam logic [7:0] SIG_0 = 8'h00;
    localparam logic [7:0] SIG_1 = 8'h01;
    localparam logic [7:0] SIG_2 = 8'h02;
    localparam logic [7:0] SIG_3 = 8'h03;
    localparam logic [7:0] SIG_4 = 8'h04;
    localparam logic [7:0] SIG_5 = 8'h05;
    localparam logic [7:0] SIG_6 = 8'h06;

    // Word counts
    localparam logic [7:0] WC_LONG = 8'h0a;
    localparam logic [7:0] WC_SHORT = 8'h08;
    localparam logic [7:0] WC_GLO = 8'h04;
    localparam logic [7:0] WC_NONE = 8'h00;

    localparam logic [7:0] SV_UNKNOWN = 8'hff;

    // Header beat fields
    localparam int HDR_GNSS_LSB = 24;
    localparam int HDR_SV_LSB = 16;
    localparam int HDR_SIG_LSB = 8;
    localparam int HDR_WC_LSB = 0;

    // GPS L1C/A word: 30 bits low, data bits above the six parity bits
    localparam int L1CA_DATA_MSB = 29;
    localparam int L1CA_DATA_LSB = 6;
    localparam int PAD_MSB = 31;
    localparam int PAD_LSB = 30;

    // GLONASS string placement: idle chip, pad bits, derived word
    localparam int GLO_IDLE_BIT = 31;
    localparam int GLO_PAD_MSB = 10;
    localparam logic [IDX_W-1:0] GLO_IDLE_WORD = 4'h0;
    localparam logic [IDX_W-1:0] GLO_TAIL_WORD = 4'h2;
    localparam logic [IDX_W-1:0] GLO_DERIVED_WORD = 4'h3;
    localparam int GLO_SUPER_LSB = 16;
    localparam int GLO_FRAME_LSB = 0;

    typedef enum logic [1:0] {
        FMT_PASS = 2'h0,
        FMT_L1CA = 2'h1,
        FMT_BDS = 2'h2,
        FMT_GLO = 2'h3
    } fmt_type;

    typedef enum logic [1:0] {
        ST_COLLECT = 2'b00,
        ST_HEADER = 2'b01,
        ST_PAYLOAD = 2'b11,
        ST_DRAIN = 2'b10
    } state_type;
endpackage : nav_report_pkg
`default_nettype wire

// >>> src/sig_format_lookup.sv
// Maps constellation and signal codes to report layout
`default_nettype none
module sig_format_lookup
    import nav_report_pkg::*;
(
    input wire logic [7:0] gnss_id,
    input wire logic [7:0] sig_id,
    output logic known,
    output logic [7:0] word_count,
    output logic [7:0] src_words,
    output fmt_type fmt
);
    always_comb begin
        known = 1'b1;
        word_count = WC_NONE;
        fmt = FMT_PASS;
        unique case (gnss_id)
            GNSS_GPS, GNSS_QZSS: begin
                if (sig_id == SIG_0) begin
                    word_count = WC_LONG;
                    fmt = FMT_L1CA;
                end else if (gnss_id == GNSS_QZSS && sig_id == SIG_1) begin
                    word_count = WC_SHORT;
                end else if ((gnss_id == GNSS_GPS && (sig_id == SIG_3 || sig_id == SIG_4))
                          || (gnss_id == GNSS_QZSS && (sig_id == SIG_4 || sig_id == SIG_5))) begin
                    word_count = WC_LONG;
                end else begin
                    known = 1'b0;
                end
            end
            GNSS_SBAS: begin
                word_count = WC_SHORT;
                known = (sig_id == SIG_0);
            end
            GNSS_GAL: begin
                word_count = WC_SHORT;
                known = (sig_id == SIG_0 || sig_id == SIG_1 || sig_id == SIG_5 || sig_id == SIG_6);
            end
            GNSS_BDS: begin
                word_count = WC_LONG;
                fmt = FMT_BDS;
                known = (sig_id <= SIG_3);
            end
            GNSS_GLO: begin
                word_count = WC_GLO;
                fmt = FMT_GLO;
                known = (sig_id == SIG_0 || sig_id == SIG_2);
            end
            default: begin
                known = 1'b0;
            end
        endcase
        if (!known) begin
            word_count = WC_NONE;
        end
        // GLONASS last word is made by the word shaper, not decoded, so one word fewer is collected
        src_words = (fmt == FMT_GLO) ? (word_count - 8'h01) : word_count;
    end
endmodule : sig_format_lookup
`default_nettype wire

// >>> src/nav_word_shaper.sv
// Per-word payload shaping: inversion, pads, idle chip
`default_nettype none
module nav_word_shaper
    import nav_report_pkg::*;
(
    input wire fmt_type fmt,
    input wire logic [IDX_W-1:0] idx,
    input wire logic [WORD_W-1:0] raw,
    input wire logic prev_d30,
    input wire logic [15:0] glo_frame,
    input wire logic [15:0] glo_super,
    output logic [WORD_W-1:0] word
);
    always_comb begin
        word = raw;
        unique case (fmt)
            FMT_L1CA: begin
                if (prev_d30) begin
                    word[L1CA_DATA_MSB:L1CA_DATA_LSB] = ~raw[L1CA_DATA_MSB:L1CA_DATA_LSB];
                end
                word[PAD_MSB:PAD_LSB] = 2'h0;
            end
            FMT_BDS: begin
                word[PAD_MSB:PAD_LSB] = 2'h0;
            end
            FMT_GLO: begin
                if (idx == GLO_IDLE_WORD) begin
                    word[GLO_IDLE_BIT] = 1'b0;
                end
                if (idx == GLO_TAIL_WORD) begin
                    word[GLO_PAD_MSB:0] = '0;
                end
                if (idx == GLO_DERIVED_WORD) begin
                    word = '0;
                    word[GLO_SUPER_LSB +: 16] = glo_super;
                    word[GLO_FRAME_LSB +: 16] = glo_frame;
                end
            end
            FMT_PASS: begin
                word = raw;
            end
        endcase
    end
endmodule : nav_word_shaper
`default_nettype wire

// >>> tb/nav_subframe_reporter_assertions.sv
// Port-level checks for the subframe report framer
`default_nettype none
module nav_report_checker
    import nav_report_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic report_enable,
    input wire logic end_valid,
    input wire logic end_parity_ok,
    input wire logic in_ready,
    input wire logic rpt_valid,
    input wire logic [WORD_W-1:0] rpt_data,
    input wire logic rpt_first,
    input wire logic rpt_last,
    input wire logic rpt_ready,
    input wire logic drop_pulse,
    input wire logic [15:0] sent_count
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic [7:0] wc_r;
    logic [7:0] gnss_r;
    logic [7:0] beat_r;
    logic end_take;
    assign end_take = end_valid && in_ready;
    function automatic logic [7:0] wc_of(input logic [7:0] g, input logic [7:0] s);
        if (g == 8'h06) return 8'h04;
        if (g == 8'h02 || g == 8'h01 || (g == 8'h05 && s == 8'h01)) return 8'h08;
        return 8'h0a;
    endfunction : wc_of
    // Header fields of the report in flight, payload beats taken
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wc_r <= 8'h00;
            gnss_r <= 8'h00;
            beat_r <= 8'h00;
        end else if (rpt_valid && rpt_ready && rpt_first) begin
            wc_r <= rpt_data[7:0];
            gnss_r <= rpt_data[31:24];
            beat_r <= 8'h00;
        end else if (rpt_valid && rpt_ready) begin
            beat_r <= beat_r + 8'h01;
        end
    end
    a_beat_held: assert property (rpt_valid && !rpt_ready |=> rpt_valid && $stable(rpt_data)
        && $stable(rpt_first) && $stable(rpt_last)) else $error("beat changed before acceptance");
    a_busy_no_input: assert property (rpt_valid |-> !in_ready) else $error("input open during report");
    a_good_or_drop: assert property (end_take && report_enable |-> (##1 drop_pulse)
        or (##2 (rpt_valid && rpt_first))) else $error("no report and no drop after end");
    a_parity_drop: assert property (end_take && report_enable && !end_parity_ok
        |=> drop_pulse ##1 !rpt_valid) else $error("failed parity not dropped");
    a_disabled_silent: assert property (end_take && !report_enable
        |=> (!drop_pulse && !rpt_valid) [*3]) else $error("activity while disabled");
    a_hdr_codes: assert property (rpt_valid && rpt_first
        |-> rpt_data[31:24] inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06}) else $error("bad constellation code");
    a_hdr_count: assert property (rpt_valid && rpt_first
        |-> rpt_data[7:0] == wc_of(rpt_data[31:24], rpt_data[15:8])) else $error("bad word count");
    a_last_count: assert property (rpt_valid && !rpt_first
        |-> rpt_last == (beat_r == wc_r - 8'h01)) else $error("last flag misplaced");
    a_sent_step: assert property (rpt_valid && rpt_ready && rpt_last
        |=> sent_count == $past(sent_count) + 16'h0001) else $error("sent count not stepped");
    a_glo_idle: assert property (rpt_valid && !rpt_first && gnss_r == 8'h06 && beat_r == 8'h00
        |-> !rpt_data[31]) else $error("idle chip not zero");
    a_bds_pads: assert property (rpt_valid && !rpt_first && gnss_r == 8'h03
        |-> rpt_data[31:30] == 2'b00) else $error("pad bits set");
    c_report_done: cover property (rpt_valid && rpt_ready && rpt_last);
    c_drop: cover property (drop_pulse);
    c_stall: cover property (rpt_valid && !rpt_ready);
endmodule : nav_report_checker
bind nav_subframe_reporter nav_report_checker u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .report_enable(report_enable), .end_valid(end_valid), .end_parity_ok(end_parity_ok),
    .in_ready(in_ready), .rpt_valid(rpt_valid), .rpt_data(rpt_data), .rpt_first(rpt_first),
    .rpt_last(rpt_last), .rpt_ready(rpt_ready), .drop_pulse(drop_pulse), .sent_count(sent_count));
`default_nettype wire

// >>> tb/nav_host_model.sv
// Host side: accepts report beats, keeps the parsed view
`default_nettype none
module nav_host_model
    import nav_report_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic slow,
    input wire logic rpt_valid,
    input wire logic [WORD_W-1:0] rpt_data,
    input wire logic rpt_first,
    input wire logic rpt_last,
    output logic rpt_ready,
    output logic [WORD_W-1:0] hdr,
    output logic [WORD_W-1:0] body [0:MAX_WORDS-1],
    output logic [15:0] nrep
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [IDX_W-1:0] idx_r;
    function automatic logic [WORD_W-1:0] keep_mask(input logic [WORD_W-1:0] h, input logic [IDX_W-1:0] i);
        if (h[31:24] == 8'h03 || ((h[31:24] == 8'h00 || h[31:24] == 8'h05) && h[15:8] == 8'h00))
            return 32'h3fffffff;
        if (h[31:24] == 8'h06 && i == 4'h2) return 32'hfffff800;
        return 32'hffffffff;
    endfunction : keep_mask
    // Stalling host toggles ready to hold beats back
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) rpt_ready <= 1'b0;
        else rpt_ready <= slow ? !rpt_ready : 1'b1;
    end
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            idx_r <= 4'h0;
            hdr <= 32'h00000000;
            nrep <= 16'h0000;
        end else if (rpt_valid && rpt_ready && rpt_first) begin
            hdr <= rpt_data;
            idx_r <= 4'h0;
        end else if (rpt_valid && rpt_ready) begin
            body[idx_r] <= rpt_data & keep_mask(hdr, idx_r);
            idx_r <= idx_r + 4'h1;
            if (rpt_last) nrep <= nrep + 16'h0001;
        end
    end
endmodule : nav_host_model
`default_nettype wire

// >>> tb/tb_nav_subframe_reporter.sv
// Self-checking bench for the subframe report framer
`default_nettype none
module tb_nav_subframe_reporter
    import nav_report_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, sys_rst = 1'b1, report_enable = 1'b0, word_valid = 1'b0, end_valid = 1'b0;
    logic [31:0] word_data = 32'h0;
    logic end_parity_ok = 1'b0, end_sv_known = 1'b0, end_prev_d30 = 1'b0, slow = 1'b0;
    logic [7:0] end_gnss_id = 8'h0, end_sig_id = 8'h0, end_sv_id = 8'h0;
    logic [15:0] end_glo_frame = 16'h0, end_glo_super = 16'h0;
    logic in_ready, rpt_valid, rpt_first, rpt_last, rpt_ready, drop_pulse;
    logic [31:0] rpt_data, hdr;
    logic [31:0] body [0:MAX_WORDS-1];
    logic [15:0] sent_count, drop_count, nrep;
    int n_mismatch = 0, total_checks = 0;
    logic [23:0] tab [0:17] = '{24'h00000a, 24'h010008, 24'h00030a, 24'h00040a, 24'h020008, 24'h020108,
        24'h020508, 24'h020608, 24'h03000a, 24'h03010a, 24'h03020a, 24'h03030a, 24'h05000a, 24'h050108,
        24'h05040a, 24'h05050a, 24'h060004, 24'h060204};
    always #20 ref_clk = !ref_clk;
    nav_subframe_reporter u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .report_enable(report_enable),
        .word_valid(word_valid), .word_data(word_data), .end_valid(end_valid), .end_parity_ok(end_parity_ok),
        .end_gnss_id(end_gnss_id), .end_sig_id(end_sig_id), .end_sv_id(end_sv_id), .end_sv_known(end_sv_known),
        .end_prev_d30(end_prev_d30), .end_glo_frame(end_glo_frame), .end_glo_super(end_glo_super),
        .in_ready(in_ready), .rpt_valid(rpt_valid), .rpt_data(rpt_data), .rpt_first(rpt_first),
        .rpt_last(rpt_last), .rpt_ready(rpt_ready), .drop_pulse(drop_pulse), .sent_count(sent_count),
        .drop_count(drop_count));
    nav_host_model u_host (.ref_clk(ref_clk), .sys_rst(sys_rst), .slow(slow), .rpt_valid(rpt_valid),
        .rpt_data(rpt_data), .rpt_first(rpt_first), .rpt_last(rpt_last), .rpt_ready(rpt_ready),
        .hdr(hdr), .body(body), .nrep(nrep));
    task automatic results();
        if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            $display("MISMATCH %0t %s got %h want %h", $time, what, got, exp);
            n_mismatch++;
        end
    endtask : cmp
    // Bit 31 set on purpose so pads and the idle chip are exercised
    function automatic logic [31:0] raw(input int k, input int i);
        return {8'h80 | 8'(i), 8'(k), 8'h5a, 8'(3 * i + k)};
    endfunction : raw
    function automatic logic [31:0] expw(input logic [7:0] g, input logic [7:0] s, input int k, input int i);
        logic [31:0] r;
        logic p;
        p = k[0];
        if (i > 0) begin
            r = raw(k, i - 1);
            p = r[0];
        end
        r = raw(k, i);
        if (g == 8'h06) return (i == 0) ? {1'b0, r[30:0]} : (i == 2) ? {r[31:11], 11'h000} :
            (i == 3) ? {16'(k), 16'(k * 5)} : r;
        if (g == 8'h03) return {2'b00, r[29:0]};
        if ((g == 8'h00 || g == 8'h05) && s == 8'h00) return {2'b00, r[29:6] ^ {24{p}}, r[5:0]};
        return r;
    endfunction : expw
    task automatic wait_ready();
        int t;
        t = 0;
        while (in_ready !== 1'b1 && t < 300) begin
            @(posedge ref_clk);
            #1;
            t++;
        end
        if (t >= 300) begin
            $display("MISMATCH %0t input never ready", $time);
            n_mismatch++;
            results();
        end
    endtask : wait_ready
    task automatic send(input logic [7:0] g, input logic [7:0] s, input int nw, input logic par, input int k);
        wait_ready();
        for (int i = 0; i < nw; i++) begin
            @(posedge ref_clk);
            word_valid <= 1'b1;
            word_data <= raw(k, i);
        end
        @(posedge ref_clk);
        word_valid <= 1'b0;
        end_valid <= 1'b1;
        end_parity_ok <= par;
        end_gnss_id <= g;
        end_sig_id <= s;
        end_sv_id <= 8'(k + 1);
        end_sv_known <= !(k[0] && g == 8'h06);
        end_prev_d30 <= k[0];
        end_glo_frame <= 16'(k * 5);
        end_glo_super <= 16'(k);
        @(posedge ref_clk);
        end_valid <= 1'b0;
        @(posedge ref_clk);
        #1;
        wait_ready();
    endtask : send
    // Every signal row, host alternating prompt and stalling
    task automatic t_table();
        logic [7:0] g, s, wc, sv;
        for (int k = 0; k < 18; k++) begin
            {g, s, wc} = tab[k];
            slow <= k[0];
            send(g, s, (g == 8'h06) ? 3 : int'(wc), 1'b1, k);
            sv = (g == 8'h06 && k[0]) ? 8'hff : 8'(k + 1);
            cmp(hdr, {g, sv, s, wc}, "header");
            cmp(32'(nrep), 32'(k + 1), "report count");
            for (int i = 0; i < wc; i++) cmp(body[i], expw(g, s, k, i), "payload");
        end
        cmp(32'(sent_count), 32'h12, "sent count");
    endtask : t_table
    // Parity fail, short, overlong, unknown signal
    task automatic t_drops();
        logic [15:0] d0, n0;
        for (int c = 0; c < 4; c++) begin
            d0 = drop_count;
            n0 = nrep;
            send((c == 3) ? 8'h04 : 8'h00, 8'h00, (c == 1) ? 9 : (c == 2) ? 11 : 10, c != 0, c);
            @(posedge ref_clk);
            #1;
            cmp(32'(drop_count), 32'(d0 + 16'h0001), "drop count");
            cmp(32'(nrep), 32'(n0), "dropped report sent");
        end
    endtask : t_drops
    task automatic t_disable();
        logic [15:0] d0, n0;
        d0 = drop_count;
        n0 = nrep;
        @(posedge ref_clk);
        report_enable <= 1'b0;
        send(8'h00, 8'h00, 10, 1'b1, 2);
        @(posedge ref_clk);
        #1;
        cmp(32'(drop_count), 32'(d0), "drop counted while disabled");
        cmp(32'(nrep), 32'(n0), "report while disabled");
        @(posedge ref_clk);
        report_enable <= 1'b1;
    endtask : t_disable
    initial begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        report_enable <= 1'b1;
        t_table();
        t_drops();
        t_disable();
        results();
    end
endmodule : tb_nav_subframe_reporter
`default_nettype wire
